// ===== rtl/cfg_readout_pkg.sv
// Package: constants and carrier types for the serial configuration read-out block
package cfg_readout_pkg;
  // ----------------------------------------
  // Memory geometry
  // ----------------------------------------
  localparam int unsigned MEM_DEPTH = 1048576;
  localparam int unsigned ADDR_W = 20;
  localparam logic [19:0] ADDR_MAX = 20'hfffff;
  localparam logic [19:0] ADDR_RESET = 20'h00000;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned FIFO_W = 1;
  localparam int unsigned FIFO_PTR_W = 5;
  // ----------------------------------------
  // Pin synchroniser and polarity
  // ----------------------------------------
  localparam int unsigned SYNC_STAGES = 3;
  localparam logic POLARITY_RESET_LOW = 1'b0;
  localparam logic [2:0] SYNC_RESET = 3'h7;
  // ----------------------------------------
  // Read-out state
  // ----------------------------------------
  typedef enum logic [1:0] {ST_RESET, ST_STANDBY, ST_READ, ST_PROGRAM} mode_t;
  typedef struct packed {
    logic chip_sel_n;
    logic rst_oe;
    logic program_select_n;
    logic sclk;
  } pins_t;
  typedef struct packed {
    logic data_o;
    logic data_oe;
    logic chain_enable_out_n;
  } drive_t;
endpackage : cfg_readout_pkg

// ===== rtl/bit_fifo.sv
// Bit FIFO: parameterised buffer between memory read port and serial driver
`timescale 1ns/1ps
`default_nettype none
module bit_fifo #(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned DEPTH = 32,
  parameter int unsigned PTR_W = 5
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic flush_i,
  // Write side
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  input wire logic [WIDTH-1:0] wr_data_i,
  // Read side
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  output logic [WIDTH-1:0] rd_data_o
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W:0] wr_ptr;
  logic [PTR_W:0] rd_ptr;
  wire full = (wr_ptr[PTR_W] != rd_ptr[PTR_W]) && (wr_ptr[PTR_W-1:0] == rd_ptr[PTR_W-1:0]);
  wire empty = (wr_ptr == rd_ptr);
  wire do_wr = wr_valid_i && !full;
  wire do_rd = rd_ready_i && !empty;
  assign wr_ready_o = !full;
  assign rd_valid_o = !empty;
  assign rd_data_o = mem[rd_ptr[PTR_W-1:0]];
  always_ff @(posedge clk_sys_i) begin
    if (do_wr) begin
      mem[wr_ptr[PTR_W-1:0]] <= wr_data_i;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || flush_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule : bit_fifo
`default_nettype wire

// ===== rtl/cfg_readout.sv
// Serial configuration memory read-out with cascade, standby and programming mode
// What this block does
// RULE_01: After last bit, chain enable low, data floats
// RULE_02: Downstream drives data once chip select low
// RULE_03: Active reset level clears address counter
// RULE_04: System may hold reset input inactive forever
// RULE_05: Reset input polarity is selectable
// RULE_06: Program select low enters programming mode
// RULE_07: Chip select high: standby, counters frozen
// RULE_08: Standby keeps data floating regardless of reset
// RULE_09: Reset level clears counters, floats data
// RULE_10: Selected and not reset: count, drive data
// RULE_11: Chain enable holds, follows select, then high
// RULE_12: Address counter cleared at power-up
// RULE_13: Next bit shown after each counted edge
// RULE_14: Full megabit address, end at maximum
`timescale 1ns/1ps
`default_nettype none
module cfg_readout (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Control pins from the master
  input wire logic chip_sel_n_i,
  input wire logic rst_oe_i,
  input wire logic program_select_n_i,
  input wire logic sclk_i,
  // Polarity setting: 0 means low level resets
  input wire logic reset_polarity_i,
  // Memory read port
  output logic [19:0] mem_addr_o,
  output logic mem_rd_o,
  input wire logic mem_data_i,
  // Serial data pin and cascade output
  output logic data_o,
  output logic data_oe_o,
  output logic chain_enable_out_n_o,
  // Status
  output logic program_mode_o,
  output logic standby_o
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] sync_ce;
  logic [2:0] sync_ro;
  logic [2:0] sync_ps;
  logic [2:0] sync_ck;
  cfg_readout_pkg::pins_t pins;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sync_ce <= cfg_readout_pkg::SYNC_RESET;
      sync_ro <= cfg_readout_pkg::SYNC_RESET;
      sync_ps <= cfg_readout_pkg::SYNC_RESET;
      sync_ck <= 3'h0;
    end else begin
      sync_ce <= {sync_ce[1:0], chip_sel_n_i};
      sync_ro <= {sync_ro[1:0], rst_oe_i};
      sync_ps <= {sync_ps[1:0], program_select_n_i};
      sync_ck <= {sync_ck[1:0], sclk_i};
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pins <= '{chip_sel_n: 1'b1, rst_oe: 1'b1, program_select_n: 1'b1, sclk: 1'b0};
    end else begin
      if (sync_ce[1] == sync_ce[2]) pins.chip_sel_n <= sync_ce[2];
      if (sync_ro[1] == sync_ro[2]) pins.rst_oe <= sync_ro[2];
      if (sync_ps[1] == sync_ps[2]) pins.program_select_n <= sync_ps[2];
      if (sync_ck[1] == sync_ck[2]) pins.sclk <= sync_ck[2];
    end
  end
  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  logic sclk_q;
  logic [19:0] addr;
  logic [19:0] next_addr;
  logic done;
  logic chain_n;
  logic rd_pending;
  cfg_readout_pkg::mode_t mode;
  wire reset_level = (pins.rst_oe == reset_polarity_i); // RULE_05
  wire program_mode = !pins.program_select_n; // RULE_06
  wire standby = pins.chip_sel_n && !program_mode; // RULE_07
  wire sclk_rise = pins.sclk && !sclk_q;
  wire active = !program_mode && !reset_level && !pins.chip_sel_n && !done;
  wire at_end = (addr == cfg_readout_pkg::ADDR_MAX); // RULE_14
  wire fifo_wr_ready;
  wire fifo_rd_valid;
  wire fifo_rd_data;
  wire count_edge = active && sclk_rise && fifo_rd_valid; // RULE_10
  assign next_addr = addr + 20'h00001;
  always_comb begin
    mode = cfg_readout_pkg::ST_READ;
    if (program_mode) mode = cfg_readout_pkg::ST_PROGRAM;
    else if (reset_level) mode = cfg_readout_pkg::ST_RESET;
    else if (pins.chip_sel_n) mode = cfg_readout_pkg::ST_STANDBY;
  end
  // ----------------------------------------
  // Address counter and prefetch
  // ----------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= pins.sclk;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      addr <= cfg_readout_pkg::ADDR_RESET; // RULE_12
      rd_pending <= 1'b0;
    end else begin
      case (mode)
        cfg_readout_pkg::ST_RESET: begin
          addr <= cfg_readout_pkg::ADDR_RESET; // RULE_03 RULE_09
          rd_pending <= 1'b0;
        end
        cfg_readout_pkg::ST_READ: begin
          rd_pending <= 1'b0;
          if (!rd_pending && fifo_wr_ready && !done) begin
            rd_pending <= 1'b1;
          end
          if (rd_pending && !at_end) begin
            addr <= next_addr;
          end
        end
        default: begin
          rd_pending <= 1'b0; // RULE_07
          if (rd_pending && !at_end) begin
            addr <= next_addr;
          end
        end
      endcase
    end
  end
  assign mem_addr_o = addr;
  assign mem_rd_o = (mode == cfg_readout_pkg::ST_READ) && !rd_pending && fifo_wr_ready && !done;
  // ----------------------------------------
  // Bit stream and end detection
  // ----------------------------------------
  logic [20:0] out_count;
  wire last_out = (out_count[19:0] == cfg_readout_pkg::ADDR_MAX);
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || mode == cfg_readout_pkg::ST_RESET) begin
      out_count <= 21'h000000; // RULE_09
      done <= 1'b0;
    end else if (count_edge) begin
      out_count <= out_count + 21'h000001;
      if (last_out) done <= 1'b1; // RULE_01
    end
  end
  bit_fifo #(
    .WIDTH(cfg_readout_pkg::FIFO_W),
    .DEPTH(cfg_readout_pkg::FIFO_DEPTH),
    .PTR_W(cfg_readout_pkg::FIFO_PTR_W)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .flush_i(mode == cfg_readout_pkg::ST_RESET),
    .wr_valid_i(rd_pending),
    .wr_ready_o(fifo_wr_ready),
    .wr_data_i(mem_data_i),
    .rd_valid_o(fifo_rd_valid),
    .rd_ready_i(count_edge),
    .rd_data_o(fifo_rd_data)
  );
  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  cfg_readout_pkg::drive_t drv;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      drv <= '{data_o: 1'b0, data_oe: 1'b0, chain_enable_out_n: 1'b1};
    end else begin
      drv.data_oe <= active && !(count_edge && last_out); // RULE_01 RULE_02 RULE_08
      if (active && fifo_rd_valid && !count_edge) drv.data_o <= fifo_rd_data; // RULE_13
      drv.chain_enable_out_n <= chain_n;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      chain_n <= 1'b1;
    end else if (reset_level || program_mode) begin
      chain_n <= 1'b1; // RULE_11
    end else if (count_edge && last_out) begin
      chain_n <= 1'b0; // RULE_01
    end else if (done) begin
      chain_n <= pins.chip_sel_n; // RULE_11
    end
  end
  assign data_o = drv.data_o;
  assign data_oe_o = drv.data_oe;
  assign chain_enable_out_n_o = drv.chain_enable_out_n;
  assign program_mode_o = program_mode;
  assign standby_o = standby;
endmodule : cfg_readout
`default_nettype wire

// ===== testbench/cfg_readout_checker.sv
// Checker: port assertions for the serial read-out block
`timescale 1ns/1ps
`default_nettype none
module cfg_readout_checker (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Watched ports
  input wire logic chip_sel_n_i,
  input wire logic rst_oe_i,
  input wire logic program_select_n_i,
  input wire logic reset_polarity_i,
  input wire logic [19:0] mem_addr_o,
  input wire logic data_oe_o,
  input wire logic chain_enable_out_n_o,
  input wire logic program_mode_o,
  input wire logic standby_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  wire logic reset_level = (rst_oe_i == reset_polarity_i);
  wire logic run_ok = !chip_sel_n_i && !reset_level && program_select_n_i && chain_enable_out_n_o;
  a_standby_float: assert property (standby_o && $past(standby_o) |-> !data_oe_o) else $error("drive in standby");
  a_standby_enter: assert property ((chip_sel_n_i && program_select_n_i)[*6] |-> standby_o) else $error("no standby");
  a_reset_float: assert property (reset_level[*6] |-> !data_oe_o) else $error("drive under reset level");
  a_reset_addr: assert property (reset_level[*8] |-> mem_addr_o == 20'h00000) else $error("address not cleared");
  a_chain_release: assert property (reset_level[*8] |-> chain_enable_out_n_o) else $error("chain stays low");
  a_select_drive: assert property (run_ok[*8] |-> data_oe_o or ##1 !chain_enable_out_n_o) else $error("no drive");
  a_program_float: assert property ((!program_select_n_i)[*6] |-> program_mode_o && !data_oe_o) else $error("program");
  a_end_float: assert property ($fell(chain_enable_out_n_o) |-> !data_oe_o) else $error("drive after end");
  a_power_reset: assert property (disable iff (1'b0) rst_i |=> chain_enable_out_n_o && !data_oe_o) else $error("reset");
  c_drive: cover property ($rose(data_oe_o));
  c_program: cover property ($rose(program_mode_o));
  c_standby: cover property ($rose(standby_o));
endmodule : cfg_readout_checker
bind cfg_readout cfg_readout_checker u_cfg_readout_checker (.clk_sys_i, .rst_i, .chip_sel_n_i, .rst_oe_i,
  .program_select_n_i, .reset_polarity_i, .mem_addr_o, .data_oe_o, .chain_enable_out_n_o, .program_mode_o, .standby_o);
`default_nettype wire

// ===== testbench/cfg_mem_model.sv
// Partner: address-pattern memory model answering the read port one cycle later
`timescale 1ns/1ps
`default_nettype none
module cfg_mem_model (
  // Read port
  input wire logic clk_sys_i,
  input wire logic [19:0] mem_addr_i,
  input wire logic mem_rd_i,
  output logic mem_data_o = 1'b0
);
  always @(posedge clk_sys_i) begin
    mem_data_o <= mem_rd_i ? (mem_addr_i[0] ^ mem_addr_i[2]) : !mem_data_o;
  end
endmodule : cfg_mem_model
`default_nettype wire

// ===== testbench/cfg_readout_bench.sv
// Bench: scenario tasks for the serial read-out block
`timescale 1ns/1ps
`default_nettype none
module cfg_readout_bench;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic cs_n = 1'b1;
  logic rst_oe = 1'b1;
  logic prog_n = 1'b1;
  logic sclk = 1'b0;
  logic pol = 1'b0;
  logic [19:0] mem_addr;
  logic mem_rd, mem_data, data, data_oe, chain_n, prog_mode, standby;
  int error_cnt = 0;
  int n_tests = 0;
  initial forever #20 clk_sys_i = ~clk_sys_i;
  cfg_readout u_cfg_readout (.clk_sys_i, .rst_i, .chip_sel_n_i(cs_n), .rst_oe_i(rst_oe), .program_select_n_i(prog_n),
    .sclk_i(sclk), .reset_polarity_i(pol), .mem_addr_o(mem_addr), .mem_rd_o(mem_rd), .mem_data_i(mem_data),
    .data_o(data), .data_oe_o(data_oe), .chain_enable_out_n_o(chain_n), .program_mode_o(prog_mode), .standby_o(standby));
  cfg_mem_model u_cfg_mem_model (.clk_sys_i, .mem_addr_i(mem_addr), .mem_rd_i(mem_rd), .mem_data_o(mem_data));
  function automatic logic pat(int a);
    return a[0] ^ a[2];
  endfunction : pat
  task automatic tick(int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : tick
  task automatic check(string what, logic [19:0] exp, logic [19:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  task automatic wait_oe();
    int i;
    for (i = 0; i < 40 && data_oe !== 1'b1; i++) tick(1);
    check("drive enable", 1'b1, data_oe);
    if (data_oe !== 1'b1) print_verdict();
    tick(2);
  endtask : wait_oe
  task automatic pulse();
    sclk = 1'b1;
    tick(5);
    sclk = 1'b0;
    tick(5);
  endtask : pulse
  task automatic t_readout();
    int i;
    cs_n = 1'b0;
    wait_oe();
    check("first bit", pat(0), data);
    for (i = 1; i < 24; i++) begin
      pulse();
      check("serial bit", pat(i), data);
    end
  endtask : t_readout
  task automatic t_standby();
    cs_n = 1'b1;
    tick(8);
    check("standby flag", 1'b1, standby);
    check("standby drive", 1'b0, data_oe);
    pulse();
    pulse();
    cs_n = 1'b0;
    wait_oe();
    check("frozen bit", pat(23), data);
    pulse();
    check("resumed bit", pat(24), data);
  endtask : t_standby
  task automatic t_reset_level();
    cs_n = 1'b1;
    rst_oe = 1'b0;
    tick(8);
    check("standby drive", 1'b0, data_oe);
    cs_n = 1'b0;
    tick(8);
    check("reset drive", 1'b0, data_oe);
    check("chain level", 1'b1, chain_n);
    rst_oe = 1'b1;
    wait_oe();
    check("restart bit", pat(0), data);
  endtask : t_reset_level
  task automatic t_polarity();
    rst_i = 1'b1;
    pol = 1'b1;
    rst_oe = 1'b0;
    tick(2);
    rst_i = 1'b0;
    wait_oe();
    check("power-up bit", pat(0), data);
    pulse();
    rst_oe = 1'b1;
    tick(8);
    check("high reset drive", 1'b0, data_oe);
    rst_oe = 1'b0;
    wait_oe();
    check("high reset bit", pat(0), data);
  endtask : t_polarity
  task automatic t_program();
    prog_n = 1'b0;
    tick(8);
    check("program flag", 1'b1, prog_mode);
    check("program drive", 1'b0, data_oe);
    prog_n = 1'b1;
    tick(8);
  endtask : t_program
  initial begin
    tick(16);
    rst_i = 1'b0;
    t_readout();
    t_standby();
    t_reset_level();
    t_program();
    t_polarity();
    print_verdict();
  end
endmodule : cfg_readout_bench
`default_nettype wire
